// ==== src/tamper_monitor_regs.vh ====
// Register map, field positions and reset values of the waveform
// threshold and neutral imbalance monitor.
// Assumes word addresses on the decoded serial register port.
`ifndef TAMPER_MONITOR_REGS_VH
`define TAMPER_MONITOR_REGS_VH

// Register addresses
`define ADDR_OVERVOLTAGE_THR 8'h00
`define ADDR_OVERCURRENT_THR 8'h01
`define ADDR_IMBALANCE_THR 8'h02
`define ADDR_PHASE_CURRENT_TOTAL 8'h03
`define ADDR_PRIMARY_FLAGS 8'h04
`define ADDR_SECONDARY_FLAGS 8'h05
`define ADDR_SECONDARY_ENABLES 8'h06
`define ADDR_PHASE_FLAGS 8'h07
`define ADDR_THIRD_CONFIG 8'h08
`define ADDR_NEUTRAL_RMS 8'h09

// Field positions
`define BIT_SAMPLE_DONE 17
`define BIT_CURRENT_EXCESS 17
`define BIT_VOLTAGE_EXCESS 18
`define BIT_IMBALANCE 20
`define LSB_VOLTAGE_PHASE 9
`define LSB_CURRENT_PHASE 3
`define BIT_RMS_SOURCE 2

// Reset values
`define FULL_SCALE_CODE 24'h514791
`define RST_OVERVOLTAGE_THR 24'h514791
`define RST_OVERCURRENT_THR 24'h514791
`define RST_IMBALANCE_THR 24'h000000

`endif

// ==== src/abs_exceed.v ====
// Magnitude comparator for one signed waveform sample.
// Assumes the limit is an unsigned level; a zero limit always hits.
`default_nettype none

module abs_exceed #(
  parameter W = 24
) (
  // Sample and level
  input wire [W-1:0] sample,
  input wire [W-1:0] limit,
  // Result
  output wire exceed
);

  wire [W-1:0] negSample;
  wire [W-1:0] magnitude;

  // Most negative code maps to 2^(W-1), which still fits unsigned
  assign negSample = ~sample + {{(W-1){1'b0}}, 1'b1};
  assign magnitude = sample[W-1] ? negSample : sample;
  assign exceed = (limit == {W{1'b0}}) | (magnitude > limit);

endmodule // abs_exceed

`default_nettype wire

// ==== src/tamper_monitor.v ====
// Waveform threshold and neutral current imbalance monitor.
// Assumes one sampleValid pulse per 8 kHz sample period with all seven
// waveform samples valid in that cycle, and a decoded register port.
// Operation
// - Compare sample magnitudes with unsigned limits
// - Full-scale limit detects only samples above full scale
// - Zero limit detects excess on every sample
// - Voltage and current limits read as 32 bits, top byte zero
// - Sum three phase currents into 28 bits
// - Sum each sample; sample-done flag marks it
// - Compare magnitude gap against imbalance limit
// - Gap above limit sets imbalance flag
// - Enabled imbalance flag pulls request line low
// - Write one clears imbalance, releases line
// - Signed limit, reset zero, nonpositive always trips
// - Imbalance limit uses current converter scale
// - Sum reads as 32 bits, top nibble zero
// - Imbalance limit sign-extended to 28 bits
// - Source select stores sum rms as neutral
// - Overvoltage sets flag and phase bit
// - Overcurrent sets flag and phase bit
// - Clearing voltage flag clears voltage phase bits
`default_nettype none
`include "tamper_monitor_regs.vh"

module tamper_monitor (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Waveform samples, valid with sampleValid
  input wire sampleValid,
  input wire [23:0] phaseAVoltageSample,
  input wire [23:0] phaseBVoltageSample,
  input wire [23:0] phaseCVoltageSample,
  input wire [23:0] phaseACurrentSample,
  input wire [23:0] phaseBCurrentSample,
  input wire [23:0] phaseCCurrentSample,
  input wire [23:0] neutralCurrentSample,
  // Results from the rms engine
  input wire rmsValid,
  input wire [23:0] rmsOfSum,
  input wire [23:0] rmsOfNeutral,
  // Register port
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  output wire [31:0] regRdData,
  output wire regRdValid,
  // Request line toward the host
  output wire secondaryRequestLineN
);

  reg [23:0] overvoltageThreshold_r;
  reg [23:0] overcurrentThreshold_r;
  reg [23:0] imbalanceThreshold_r;
  reg [27:0] phaseCurrentTotal_r;
  reg sampleDoneFlag_r;
  reg voltageExcessFlag_r;
  reg currentExcessFlag_r;
  reg neutralImbalanceFlag_r;
  reg [2:0] voltageExcessPhaseBits_r;
  reg [2:0] currentExcessPhaseBits_r;
  reg enVoltage_r;
  reg enCurrent_r;
  reg enImbalance_r;
  reg neutralRmsSourceSelect_r;
  reg [23:0] neutralRmsValue_r;
  reg [31:0] regRdData_r;
  reg regRdValid_r;
  reg secondaryRequestLineN_r;

  reg [31:0] rdMux;

  // Six magnitude comparators, voltages first then currents
  wire [143:0] chanSamples;
  wire [5:0] chanHit;
  wire [2:0] voltageHit;
  wire [2:0] currentHit;

  assign chanSamples = {phaseCCurrentSample, phaseBCurrentSample,
                        phaseACurrentSample, phaseCVoltageSample,
                        phaseBVoltageSample, phaseAVoltageSample};

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : chanCmp
      abs_exceed #(
        .W(24)
      ) abs_exceed_inst (
        .sample(chanSamples[g*24 +: 24]),
        .limit(g < 3 ? overvoltageThreshold_r : overcurrentThreshold_r),
        .exceed(chanHit[g])
      );
    end
  endgenerate

  assign voltageHit = chanHit[2:0] & {3{sampleValid}};
  assign currentHit = chanHit[5:3] & {3{sampleValid}};

  // Phase current sum and neutral comparison
  wire [27:0] iaWide;
  wire [27:0] ibWide;
  wire [27:0] icWide;
  wire [27:0] inWide;
  wire [27:0] totalNxt;
  wire [27:0] absTotal;
  wire [27:0] absNeutral;
  wire [27:0] magnitudeGap;
  wire [27:0] imbalanceLimit;
  wire limitNonPositive;
  wire imbalanceHit;

  assign iaWide = {{4{phaseACurrentSample[23]}}, phaseACurrentSample};
  assign ibWide = {{4{phaseBCurrentSample[23]}}, phaseBCurrentSample};
  assign icWide = {{4{phaseCCurrentSample[23]}}, phaseCCurrentSample};
  assign inWide = {{4{neutralCurrentSample[23]}}, neutralCurrentSample};
  // Three 24-bit codes cannot overflow 28 bits
  assign totalNxt = iaWide + ibWide + icWide;
  assign absTotal = totalNxt[27] ? (28'h0000000 - totalNxt) : totalNxt;
  assign absNeutral = inWide[27] ? (28'h0000000 - inWide) : inWide;
  assign magnitudeGap = (absTotal >= absNeutral) ?
                        (absTotal - absNeutral) :
                        (absNeutral - absTotal);
  // Limit shares the raw current code scale, no rescaling
  assign imbalanceLimit = {{4{imbalanceThreshold_r[23]}},
                           imbalanceThreshold_r};
  assign limitNonPositive = imbalanceLimit[27] |
                            (imbalanceLimit == 28'h0000000);
  // Limit is positive whenever the magnitude compare decides
  assign imbalanceHit = sampleValid &
                        (limitNonPositive |
                         (magnitudeGap > imbalanceLimit));

  // Register write decode
  wire wrOverV;
  wire wrOverI;
  wire wrImbal;
  wire wrPrimary;
  wire wrSecondary;
  wire wrEnables;
  wire wrConfig;
  wire clrSampleDone;
  wire clrVoltage;
  wire clrCurrent;
  wire clrImbalance;

  assign wrOverV = regWr & (regAddr == `ADDR_OVERVOLTAGE_THR);
  assign wrOverI = regWr & (regAddr == `ADDR_OVERCURRENT_THR);
  assign wrImbal = regWr & (regAddr == `ADDR_IMBALANCE_THR);
  assign wrPrimary = regWr & (regAddr == `ADDR_PRIMARY_FLAGS);
  assign wrSecondary = regWr & (regAddr == `ADDR_SECONDARY_FLAGS);
  assign wrEnables = regWr & (regAddr == `ADDR_SECONDARY_ENABLES);
  assign wrConfig = regWr & (regAddr == `ADDR_THIRD_CONFIG);
  assign clrSampleDone = wrPrimary & regWrData[`BIT_SAMPLE_DONE];
  assign clrVoltage = wrSecondary & regWrData[`BIT_VOLTAGE_EXCESS];
  assign clrCurrent = wrSecondary & regWrData[`BIT_CURRENT_EXCESS];
  assign clrImbalance = wrSecondary & regWrData[`BIT_IMBALANCE];

  // Thresholds and configuration
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      overvoltageThreshold_r <= `RST_OVERVOLTAGE_THR;
      overcurrentThreshold_r <= `RST_OVERCURRENT_THR;
      imbalanceThreshold_r <= `RST_IMBALANCE_THR;
      enVoltage_r <= 1'b0;
      enCurrent_r <= 1'b0;
      enImbalance_r <= 1'b0;
      neutralRmsSourceSelect_r <= 1'b0;
    end else begin
      // Upper byte of a written word is dropped
      if (wrOverV) begin
        overvoltageThreshold_r <= regWrData[23:0];
      end
      if (wrOverI) begin
        overcurrentThreshold_r <= regWrData[23:0];
      end
      // Bits above the 24-bit code are ignored on write
      if (wrImbal) begin
        imbalanceThreshold_r <= regWrData[23:0];
      end
      if (wrEnables) begin
        enVoltage_r <= regWrData[`BIT_VOLTAGE_EXCESS];
        enCurrent_r <= regWrData[`BIT_CURRENT_EXCESS];
        enImbalance_r <= regWrData[`BIT_IMBALANCE];
      end
      if (wrConfig) begin
        neutralRmsSourceSelect_r <= regWrData[`BIT_RMS_SOURCE];
      end
    end
  end

  // Sum, rms capture and event flags; a new event beats a clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseCurrentTotal_r <= 28'h0000000;
      neutralRmsValue_r <= 24'h000000;
      sampleDoneFlag_r <= 1'b0;
      voltageExcessFlag_r <= 1'b0;
      currentExcessFlag_r <= 1'b0;
      neutralImbalanceFlag_r <= 1'b0;
      voltageExcessPhaseBits_r <= 3'h0;
      currentExcessPhaseBits_r <= 3'h0;
    end else begin
      if (sampleValid) begin
        phaseCurrentTotal_r <= totalNxt;
      end
      if (rmsValid) begin
        neutralRmsValue_r <= neutralRmsSourceSelect_r ?
                             rmsOfSum : rmsOfNeutral;
      end
      sampleDoneFlag_r <= (sampleDoneFlag_r & ~clrSampleDone) |
                          sampleValid;
      voltageExcessFlag_r <= (voltageExcessFlag_r & ~clrVoltage) |
                             (|voltageHit);
      voltageExcessPhaseBits_r <= (voltageExcessPhaseBits_r &
                                   ~{3{clrVoltage}}) | voltageHit;
      currentExcessFlag_r <= (currentExcessFlag_r & ~clrCurrent) |
                             (|currentHit);
      currentExcessPhaseBits_r <= (currentExcessPhaseBits_r &
                                   ~{3{clrCurrent}}) | currentHit;
      neutralImbalanceFlag_r <= (neutralImbalanceFlag_r & ~clrImbalance) |
                                imbalanceHit;
    end
  end

  // Request line follows the flags one cycle later
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      secondaryRequestLineN_r <= 1'b1;
    end else begin
      secondaryRequestLineN_r <= ~((voltageExcessFlag_r & enVoltage_r) |
                                   (currentExcessFlag_r & enCurrent_r) |
                                   (neutralImbalanceFlag_r &
                                    enImbalance_r));
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @* begin
    rdMux = 32'h00000000;
    case (regAddr)
      `ADDR_OVERVOLTAGE_THR: begin
        rdMux = {8'h00, overvoltageThreshold_r};
      end
      `ADDR_OVERCURRENT_THR: begin
        rdMux = {8'h00, overcurrentThreshold_r};
      end
      `ADDR_IMBALANCE_THR: begin
        rdMux = {4'h0, imbalanceLimit};
      end
      `ADDR_PHASE_CURRENT_TOTAL: begin
        rdMux = {4'h0, phaseCurrentTotal_r};
      end
      `ADDR_PRIMARY_FLAGS: begin
        rdMux[`BIT_SAMPLE_DONE] = sampleDoneFlag_r;
      end
      `ADDR_SECONDARY_FLAGS: begin
        rdMux[`BIT_VOLTAGE_EXCESS] = voltageExcessFlag_r;
        rdMux[`BIT_CURRENT_EXCESS] = currentExcessFlag_r;
        rdMux[`BIT_IMBALANCE] = neutralImbalanceFlag_r;
      end
      `ADDR_SECONDARY_ENABLES: begin
        rdMux[`BIT_VOLTAGE_EXCESS] = enVoltage_r;
        rdMux[`BIT_CURRENT_EXCESS] = enCurrent_r;
        rdMux[`BIT_IMBALANCE] = enImbalance_r;
      end
      `ADDR_PHASE_FLAGS: begin
        rdMux[`LSB_VOLTAGE_PHASE +: 3] = voltageExcessPhaseBits_r;
        rdMux[`LSB_CURRENT_PHASE +: 3] = currentExcessPhaseBits_r;
      end
      `ADDR_THIRD_CONFIG: begin
        rdMux[`BIT_RMS_SOURCE] = neutralRmsSourceSelect_r;
      end
      `ADDR_NEUTRAL_RMS: begin
        rdMux = {8'h00, neutralRmsValue_r};
      end
      default: begin
        rdMux = 32'h00000000;
      end
    endcase
  end

  // Read data is registered so the port sees a clean word
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData_r <= 32'h00000000;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRd;
      if (regRd) begin
        regRdData_r <= rdMux;
      end
    end
  end

  assign regRdData = regRdData_r;
  assign regRdValid = regRdValid_r;
  assign secondaryRequestLineN = secondaryRequestLineN_r;

endmodule // tamper_monitor

`default_nettype wire

// ==== tb/tamper_monitor_checker.sv ====
// Port-level checks of the tamper monitor register port and request line.
// Assumes the word address map of the block header.
`default_nettype none
module tamper_monitor_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sample strobe and register port
  input wire logic sampleValid,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid,
  // Request line
  input wire logic secondaryRequestLineN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // A sample in the same cycle would win over the clear
  sequence clear_all;
    regWr && regAddr == 8'h05 && regWrData[20] && regWrData[18] &&
      regWrData[17] && !sampleValid;
  endsequence
  rd_answer_a: assert property (regRd |=> regRdValid)
    else $error("read not answered");
  rd_quiet_a: assert property (!regRd |=> !regRdValid)
    else $error("read valid without read");
  rd_hold_a: assert property (!regRd |=> $stable(regRdData))
    else $error("read data moved without read");
  limit_pad_a: assert property (
    regRd && regAddr <= 8'h01 |=> regRdData[31:24] == 8'h00)
    else $error("limit top byte not zero");
  total_pad_a: assert property (
    regRd && regAddr == 8'h03 |=> regRdData[31:28] == 4'h0)
    else $error("total top nibble not zero");
  level_sext_a: assert property (
    regRd && regAddr == 8'h02 |=> regRdData[31:28] == 4'h0 &&
      regRdData[27:24] == {4{regRdData[23]}})
    else $error("imbalance limit not sign extended");
  unmapped_zero_a: assert property (
    regRd && regAddr > 8'h09 |=> regRdData == 32'h00000000)
    else $error("unmapped read not zero");
  line_release_a: assert property (
    clear_all |-> ##2 secondaryRequestLineN)
    else $error("request line not released");
endmodule // tamper_monitor_checker

bind tamper_monitor tamper_monitor_checker tamper_monitor_checker_inst (
  .clk(clk),
  .rst(rst),
  .sampleValid(sampleValid),
  .regWr(regWr),
  .regRd(regRd),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .regRdValid(regRdValid),
  .secondaryRequestLineN(secondaryRequestLineN)
);
`default_nettype wire

// ==== tb/host_model.sv ====
// Host side of the register port: single word reads and writes.
// Assumes its tasks are called from one process only.
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output var logic regWr,
  output var logic regRd,
  output var logic [7:0] regAddr,
  output var logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h00000000;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    // Data is no longer qualified, so do not leave it standing
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    // Answer is registered; take it at the edge that samples it valid
    @(posedge clk);
    q = regRdValid === 1'b1 ? regRdData : 32'hXXXXXXXX;
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/waveform_threshold_tamper_monitor_test.sv ====
// Self-checking bench: tamper monitor against an integer register model.
// Assumes the host model drives the register port.
`default_nettype none
module waveform_threshold_tamper_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, sampleValid = 1'b0, rmsValid = 1'b0;
  logic [23:0] smp [7];
  logic [23:0] rmsSum = 24'h000000, rmsNeu = 24'h000000;
  logic regWr, regRd, regRdValid, lineN;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, q;
  int m [10];
  int seed = 78, error_cnt = 0, tests_run = 0, lim;
  always #2.5 clk = ~clk;
  tamper_monitor tamper_monitor_inst (.clk(clk), .rst(rst),
    .sampleValid(sampleValid), .phaseAVoltageSample(smp[0]),
    .phaseBVoltageSample(smp[1]), .phaseCVoltageSample(smp[2]),
    .phaseACurrentSample(smp[3]), .phaseBCurrentSample(smp[4]),
    .phaseCCurrentSample(smp[5]), .neutralCurrentSample(smp[6]),
    .rmsValid(rmsValid), .rmsOfSum(rmsSum), .rmsOfNeutral(rmsNeu),
    .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .secondaryRequestLineN(lineN));
  host_model host_model_inst (.clk(clk), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid));
  function automatic int mag(input int v);
    return v < 0 ? -v : v;
  endfunction
  function automatic int sx(input logic [23:0] v);
    return int'(signed'(v));
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // Reads every register plus two unmapped words, then the line
  task automatic chk();
    for (int a = 0; a < 12; a++) begin
      host_model_inst.rd(8'(a < 10 ? a : 32'hF0 + a), q);
      cmp($sformatf("reg %0d", a), a < 10 ? m[a] : 0, q);
    end
    cmp("line", {31'h0, (m[5] & m[6]) == 0}, {31'h0, lineN});
  endtask
  task automatic wr(input int a, input int d);
    host_model_inst.wr(8'(a), d);
    case (a)
      0, 1: m[a] = d & 32'h00FFFFFF;
      2: m[2] = sx(d[23:0]) & 32'h0FFFFFFF;
      4: m[4] &= ~(d & 32'h00020000);
      5: begin
        m[5] &= ~(d & 32'h00160000);
        if (d[18]) m[7] &= ~32'h00000E00;
        if (d[17]) m[7] &= ~32'h00000038;
      end
      6: m[6] = d & 32'h00160000;
      8: m[8] = d & 32'h00000004;
      default: ;
    endcase
  endtask
  task automatic samp(input int amp);
    int v [7];
    int sum, thr;
    @(posedge clk);
    for (int i = 0; i < 6; i++) v[i] = $random(seed) % amp;
    sum = v[3] + v[4] + v[5];
    v[6] = amp > 32'h1000 ? $random(seed) % amp : sum + $random(seed) % 32'h80;
    for (int i = 0; i < 7; i++) smp[i] <= v[i][23:0];
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (m[0] == 0 || mag(v[i]) > m[0]) m[7] |= 1 << (9 + i);
      if (m[1] == 0 || mag(v[i + 3]) > m[1]) m[7] |= 1 << (3 + i);
    end
    if (m[7] & 32'h00000E00) m[5] |= 32'h00040000;
    if (m[7] & 32'h00000038) m[5] |= 32'h00020000;
    thr = sx(m[2][23:0]);
    if (thr <= 0 || mag(mag(sum) - mag(v[6])) > thr) m[5] |= 32'h00100000;
    m[3] = sum & 32'h0FFFFFFF;
    m[4] |= 32'h00020000;
  endtask
  task automatic rms(input int sel);
    wr(8, sel);
    @(posedge clk);
    rmsSum <= 24'($random(seed));
    rmsNeu <= 24'($random(seed));
    rmsValid <= 1'b1;
    @(posedge clk);
    rmsValid <= 1'b0;
    m[9] = sel ? rmsSum : rmsNeu;
  endtask
  initial begin
    foreach (smp[i]) smp[i] = 24'h000000;
    m = '{0: 32'h00514791, 1: 32'h00514791, default: 0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr(3, -1);
    chk();
    wr(2, 32'h00000100);
    wr(6, 32'h00160000);
    for (int k = 0; k < 12; k++) begin
      lim = k % 4 == 0 ? 32'h00514791 : 0;
      if (k % 4 == 1 || k % 4 == 2) lim = $random(seed) & 32'h003FFFFF;
      wr(0, lim);
      wr(1, lim);
      if (k == 8) wr(2, 32'h00FFFF00);
      samp(k % 2 ? 32'h1000 : 32'h514792);
      chk();
      wr(5, 32'h00160000);
      wr(4, 32'h00020000);
      chk();
    end
    rms(4);
    chk();
    rms(0);
    chk();
    // Mid-run reset must bring every register back to its reset value
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m = '{0: 32'h00514791, 1: 32'h00514791, default: 0};
    chk();
    complete_run();
  end
  initial begin
    #100us;
    error_cnt++;
    complete_run();
  end
endmodule // waveform_threshold_tamper_monitor_test
`default_nettype wire
